// >>> src/rclp_consts.vh
/*
 * constants of the reset configuration and low-power control block:
 * register offsets, field positions, reset values and mode codes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef RCLP_CONSTS_VH
`define RCLP_CONSTS_VH

// register byte offsets
`define RCLP_OFS_LPCTL      12'h000
`define RCLP_OFS_PERIPH_EN  12'h004
`define RCLP_OFS_CONFIG     12'h008
`define RCLP_OFS_STATUS     12'h00C

// low-power control register fields
`define RCLP_LPCTL_MODE_LO  0
`define RCLP_LPCTL_BUS_CLOCK_OUTPUT   2
`define RCLP_LPCTL_DBGREQ   3

// low-power mode codes
`define RCLP_MODE_RUN       2'b00
`define RCLP_MODE_DOZE      2'b01
`define RCLP_MODE_WAIT      2'b10
`define RCLP_MODE_STOP      2'b11

// boot width strap codes
`define RCLP_BOOT_8         2'b10
`define RCLP_BOOT_16        2'b01

// config register fields
`define RCLP_CFG_BOOT_LO    0
`define RCLP_CFG_CLK_LO     2
`define RCLP_CFG_CS_LO      4
`define RCLP_CFG_JTAG       6
`define RCLP_CFG_STRAPPED   7

// reset values
`define RCLP_RST_LPCTL      4'h0
`define RCLP_RST_PERIPH_EN  8'hFF
`define RCLP_RST_BOOT       2'b00
`define RCLP_RST_CLK        2'b11
`define RCLP_RST_CS         2'b00

// bus responses
`define RCLP_RESP_OKAY      2'b00
`define RCLP_RESP_SLVERR    2'b10

// stop entry drain cycles
`define RCLP_STOP_DRAIN     4'h4

`endif

// >>> src/rclp_ctrl.v
/*
 * reset-time strap capture and low-power mode control with an
 * axi4-lite register slave. assumes a 10 MHz aclk, a synchronous
 * active-low reset, and straps/debug pins asynchronous to aclk.
 */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
// Functional notes
// R1 - config enable low means straps are sampled; high means defaults apply
// R2 - boot width straps: 00/11 32-bit, 10 8-bit, 01 16-bit; default 32-bit
// R3 - clock straps: 00 ext no pll, 01 1:1 pll, 10 pll ext ref, 11 xtal
// R4 - cs straps split upper address pins: 00 addr, 10 cs6, 01 cs6-5, 11 cs6-4
// R5 - low power entered only after mode bits written and stop executed
// R6 - mode code passed to clock control, which gates clocks per mode
// R7 - in stop the system clock is held low
// R8 - wakeup on reset, debug break, debug request bit or interrupt
// R9 - wait gates only core and memory clocks
// R10 - in wait enabled peripherals stay clocked and their interrupts wake
// R11 - doze gates the core like wait; code visible to all peripherals
// R12 - in doze running peripheral interrupts return to run
// R13 - stopped peripherals resume when doze exits
// R14 - stop gates the core and halts all system clocks
// R15 - stop entry waits for operations in progress to finish
// R16 - after stop, peripherals keep their state; no reinitialisation
// R17 - software disables peripherals individually, stopping their clock
// R18 - disabled peripherals stay disabled through all mode changes
// R19 - bus clock output pin can be turned off independently of mode
// R20 - debug port select high gives jtag pins; low keeps background debug
// R21 - straps captured during reset and held after release
// R22 - two-bit mode field, one distinct code per mode
`timescale 1ns/1ps
`default_nettype none
`include "rclp_consts.vh"

module rclp_ctrl (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // strap pins
    input  wire        config_strap_enable_n,
    input  wire        boot_width_strap_hi,
    input  wire        boot_width_strap_lo,
    input  wire        clock_source_strap_hi,
    input  wire        clock_source_strap_lo,
    input  wire        cs_split_strap_hi,
    input  wire        cs_split_strap_lo,
    input  wire        debug_port_select,
    // core and wakeup sources
    input  wire        stop_exec,
    input  wire        bus_busy,
    input  wire        debug_break_request_n,
    input  wire        irq_valid,
    // configuration outputs
    output reg  [1:0]  boot_width_cfg,
    output reg  [1:0]  clock_source_cfg,
    output reg  [2:0]  upper_addr_cs_sel,
    output reg         jtag_mode,
    // clock control outputs
    output reg  [1:0]  low_power_mode_field,
    output reg         core_clk_en,
    output reg         mem_clk_en,
    output reg         sys_clk_en,
    output reg  [7:0]  periph_clk_en,
    output reg         bus_clock_output_en,
    output reg         core_idle
);

    ////////////////////////////////////////////////////////////////////////
    // state codes
    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_DRAIN = 2'b01;
    localparam [1:0] ST_LOW   = 2'b10;

    // decode upper address pin split, bit set means chip select
    function [2:0] cs_split;
        input [1:0] code;
        begin
            case (code)
                2'b10:   cs_split = 3'b100;
                2'b01:   cs_split = 3'b110;
                2'b11:   cs_split = 3'b111;
                default: cs_split = 3'b000;
            endcase
        end
    endfunction

    // merge bytes of a write by strobe
    function [7:0] merge_byte;
        input [7:0] old_v;
        input [7:0] new_v;
        input       en;
        begin
            merge_byte = en ? new_v : old_v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg  [8:0] pin_s1_q;
    reg  [8:0] pin_s2_q;
    wire [8:0] pin_raw = {config_strap_enable_n, boot_width_strap_hi, boot_width_strap_lo,
                          clock_source_strap_hi, clock_source_strap_lo, cs_split_strap_hi,
                          cs_split_strap_lo, debug_port_select, debug_break_request_n};

    always @(posedge aclk) begin
        pin_s1_q <= pin_raw;
        pin_s2_q <= pin_s1_q;
    end

    wire       cfg_en_n_s   = pin_s2_q[8];
    wire [1:0] boot_s       = pin_s2_q[7:6];
    wire [1:0] clk_s        = pin_s2_q[5:4];
    wire [1:0] cs_s         = pin_s2_q[3:2];
    wire       jtag_s       = pin_s2_q[1];
    wire       brk_n_s      = pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // strap capture while reset is held
    reg [1:0] boot_q;
    reg [1:0] clk_q;
    reg [1:0] cs_q;
    reg       jtag_q;
    reg       strapped_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            if (!cfg_en_n_s) begin                          // R1 R21
                boot_q     <= boot_s;                       // R2
                clk_q      <= clk_s;                        // R3
                cs_q       <= cs_s;                         // R4
                strapped_q <= 1'b1;
            end else begin
                boot_q     <= `RCLP_RST_BOOT;               // R1
                clk_q      <= `RCLP_RST_CLK;
                cs_q       <= `RCLP_RST_CS;
                strapped_q <= 1'b0;
            end
            jtag_q <= jtag_s;                               // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    reg [1:0] mode_q;
    reg       bus_clock_output_off_q;
    reg       dbgreq_q;
    reg [7:0] periph_en_q;
    reg [1:0] st_q;
    reg [3:0] drain_q;

    wire wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
    wire wr_lp   = wr_fire && (s_axi_awaddr == `RCLP_OFS_LPCTL);
    wire wr_pe   = wr_fire && (s_axi_awaddr == `RCLP_OFS_PERIPH_EN);
    wire wr_map  = wr_lp || wr_pe || (s_axi_awaddr == `RCLP_OFS_CONFIG) ||
                   (s_axi_awaddr == `RCLP_OFS_STATUS);

    // wakeup sources, debug request bit included
    wire wake = !brk_n_s || irq_valid || dbgreq_q;           // R8

    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q       <= `RCLP_MODE_RUN;
            bus_clock_output_off_q <= 1'b0;
            dbgreq_q     <= 1'b0;
            periph_en_q  <= `RCLP_RST_PERIPH_EN;
        end else begin
            if (wr_lp && s_axi_wstrb[0]) begin
                mode_q       <= s_axi_wdata[`RCLP_LPCTL_MODE_LO +: 2];  // R22
                bus_clock_output_off_q <= s_axi_wdata[`RCLP_LPCTL_BUS_CLOCK_OUTPUT];        // R19
            end
            // debug request: set by software, consumed once the sequencer leaves run,
            // so a request that aborts a drain cannot block every later stop
            if (wr_lp && s_axi_wstrb[0])
                dbgreq_q <= s_axi_wdata[`RCLP_LPCTL_DBGREQ];
            else if (st_q != ST_RUN)
                dbgreq_q <= 1'b0;
            // enables change only by software, never by mode
            if (wr_pe)
                periph_en_q <= merge_byte(periph_en_q, s_axi_wdata[7:0],
                                          s_axi_wstrb[0]);               // R17 R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low-power sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q    <= ST_RUN;
            drain_q <= 4'h0;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (stop_exec && mode_q != `RCLP_MODE_RUN) begin    // R5
                        st_q    <= ST_DRAIN;
                        drain_q <= `RCLP_STOP_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    // let bus activity end before clocks go
                    if (wake)
                        st_q <= ST_RUN;
                    else if (drain_q != 4'h0)
                        drain_q <= drain_q - 4'h1;
                    else if (!bus_busy)
                        st_q <= ST_LOW;                                 // R15
                end
                ST_LOW: begin
                    if (wake)
                        st_q <= ST_RUN;                                 // R8 R10 R12
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gating outputs
    wire       in_low  = (st_q == ST_LOW);
    wire [1:0] eff_md  = in_low ? mode_q : `RCLP_MODE_RUN;
    wire       stop_md = in_low && (mode_q == `RCLP_MODE_STOP);
    wire       doze_md = in_low && (mode_q == `RCLP_MODE_DOZE);

    always @(posedge aclk) begin
        if (!aresetn) begin
            low_power_mode_field <= `RCLP_MODE_RUN;
            core_clk_en          <= 1'b1;
            mem_clk_en           <= 1'b1;
            sys_clk_en           <= 1'b1;
            periph_clk_en        <= `RCLP_RST_PERIPH_EN;
            bus_clock_output_en  <= 1'b1;
            core_idle            <= 1'b0;
        end else begin
            low_power_mode_field <= eff_md;                             // R6 R11
            core_clk_en          <= !in_low;                            // R9 R11 R14
            mem_clk_en           <= !in_low;                            // R9
            // stop: enable low gates clock low, state kept in flops
            sys_clk_en           <= !stop_md;                           // R7 R14 R16
            // doze stop comes from peripherals watching the field
            periph_clk_en        <= stop_md ? 8'h00 : periph_en_q;      // R10 R13 R17 R18
            bus_clock_output_en  <= !bus_clock_output_off_q && !stop_md;          // R19
            core_idle            <= in_low || doze_md;                  // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            boot_width_cfg    <= `RCLP_RST_BOOT;
            clock_source_cfg  <= `RCLP_RST_CLK;
            upper_addr_cs_sel <= 3'b000;
            jtag_mode         <= 1'b0;
        end else begin
            boot_width_cfg    <= boot_q;                                // R2
            clock_source_cfg  <= clk_q;                                 // R3
            upper_addr_cs_sel <= cs_split(cs_q);                        // R4
            jtag_mode         <= jtag_q;                                // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: single cycle acceptance, response in the same cycle as the ready
    reg [31:0] rd_mux;

    always @* begin
        case (s_axi_araddr)
            `RCLP_OFS_LPCTL:     rd_mux = {28'h000_0000, dbgreq_q, bus_clock_output_off_q, mode_q};
            `RCLP_OFS_PERIPH_EN: rd_mux = {24'h00_0000, periph_en_q};
            `RCLP_OFS_CONFIG:    rd_mux = {24'h00_0000, strapped_q, jtag_q, cs_q, clk_q,
                                           boot_q};
            `RCLP_OFS_STATUS:    rd_mux = {28'h000_0000, bus_busy, core_idle, st_q};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RCLP_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RCLP_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            // write channel
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awready) begin
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_map ? `RCLP_RESP_OKAY : `RCLP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // read channel
            s_axi_arready <= 1'b0;
            if (rd_fire && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= (s_axi_araddr[11:4] == 8'h00 && s_axi_araddr[1:0] == 2'b00)
                                 ? `RCLP_RESP_OKAY : `RCLP_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // rclp_ctrl
`default_nettype wire

// >>> testbench/rclp_core_model.sv
/* core model: pulses stop_exec on request and keeps a bus transfer busy.
   assumes go is driven on aclk by the bench. */
`timescale 1ns/1ps
`default_nettype none
module rclp_core_model (
    // clock
    input wire logic       aclk,
    // bench commands
    input wire logic       go,
    input wire logic [3:0] hold,
    // core pins
    output var logic       stop_exec,
    output var logic       bus_busy
);
    logic [3:0] cnt_q = 4'h0;
    initial stop_exec = 1'b0;
    initial bus_busy = 1'b0;
    // stop pulse, then a transfer still running for hold cycles
    always @(posedge aclk) begin
        stop_exec <= go;
        cnt_q <= go ? hold : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
        bus_busy <= go || cnt_q > 4'h1;
    end
endmodule // rclp_core_model
`default_nettype wire

// >>> testbench/rclp_ctrl_monitor.sv
/* checker for rclp_ctrl: clock gating, low-power entry and wake, strap hold.
   bound to every rclp_ctrl instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module rclp_ctrl_monitor (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // core side inputs
    input wire logic       bus_busy,
    input wire logic       irq_valid,
    // watched outputs
    input wire logic [1:0] boot_width_cfg,
    input wire logic [1:0] clock_source_cfg,
    input wire logic [2:0] upper_addr_cs_sel,
    input wire logic [1:0] low_power_mode_field,
    input wire logic       core_clk_en,
    input wire logic       mem_clk_en,
    input wire logic       sys_clk_en,
    input wire logic [7:0] periph_clk_en,
    input wire logic       core_idle
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_stop_gate;
        low_power_mode_field == 2'h3 |-> !sys_clk_en && !core_clk_en && periph_clk_en == 8'h00;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("stop leaves a clock running");
    property p_wait_gate;
        low_power_mode_field == 2'h2 |-> !core_clk_en && !mem_clk_en && sys_clk_en;
    endproperty
    a_wait_gate: assert property (p_wait_gate) else $error("wait gating wrong");
    property p_doze_gate;
        low_power_mode_field == 2'h1 |-> !core_clk_en && !mem_clk_en && sys_clk_en;
    endproperty
    a_doze_gate: assert property (p_doze_gate) else $error("doze gating wrong");
    property p_run_clk;
        !core_idle |-> core_clk_en && sys_clk_en && low_power_mode_field == 2'h0;
    endproperty
    a_run_clk: assert property (p_run_clk) else $error("clocks gated while running");
    property p_idle_code;
        core_idle |-> low_power_mode_field != 2'h0;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle shows run code");
    property p_drain;
        $rose(core_idle) |-> !$past(bus_busy, 2);
    endproperty
    a_drain: assert property (p_drain) else $error("clocks cut while bus busy");
    property p_irq_wake;
        core_idle && irq_valid |-> ##[1:3] !core_idle;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("no wake on interrupt");
    property p_strap_hold;
        $past(aresetn, 2) |-> $stable(boot_width_cfg) && $stable(clock_source_cfg)
            && $stable(upper_addr_cs_sel);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("config moved after reset");
    property p_cs_code;
        upper_addr_cs_sel inside {3'h0, 3'h4, 3'h6, 3'h7};
    endproperty
    a_cs_code: assert property (p_cs_code) else $error("illegal pin split");
endmodule // rclp_ctrl_monitor

bind rclp_ctrl rclp_ctrl_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .bus_busy(bus_busy),
    .irq_valid(irq_valid), .boot_width_cfg(boot_width_cfg), .clock_source_cfg(clock_source_cfg),
    .upper_addr_cs_sel(upper_addr_cs_sel), .low_power_mode_field(low_power_mode_field),
    .core_clk_en(core_clk_en), .mem_clk_en(mem_clk_en), .sys_clk_en(sys_clk_en),
    .periph_clk_en(periph_clk_en), .core_idle(core_idle));
`default_nettype wire

// >>> testbench/rclp_ctrl_tb.sv
/* bench for rclp_ctrl: straps, registers, low-power entry and wake.
   assumes the core model drives stop_exec and bus_busy. */
`timescale 1ns/1ps
`default_nettype none
module rclp_ctrl_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, en_n = 1'b1, dps = 1'b0, brk_n = 1'b1;
    logic        irq = 1'b0, go = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic [1:0]  bw = 2'h0, ck = 2'h0, cs = 2'h0, bresp, rresp, r, boot_cfg, clk_cfg, mode;
    logic        stop_exec, bus_busy, jtag, idle, core_en, mem_en, sys_en, bco;
    logic [2:0]  cs_sel;
    logic [7:0]  pen;
    int          n_mismatch = 0, n_checks = 0;

    // 10 MHz clock
    always #50 aclk = ~aclk;
    rclp_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .config_strap_enable_n(en_n), .boot_width_strap_hi(bw[1]), .boot_width_strap_lo(bw[0]),
        .clock_source_strap_hi(ck[1]), .clock_source_strap_lo(ck[0]),
        .cs_split_strap_hi(cs[1]), .cs_split_strap_lo(cs[0]), .debug_port_select(dps),
        .stop_exec(stop_exec), .bus_busy(bus_busy), .debug_break_request_n(brk_n),
        .irq_valid(irq), .boot_width_cfg(boot_cfg), .clock_source_cfg(clk_cfg),
        .upper_addr_cs_sel(cs_sel), .jtag_mode(jtag), .low_power_mode_field(mode),
        .core_clk_en(core_en), .mem_clk_en(mem_en), .sys_clk_en(sys_en), .periph_clk_en(pen),
        .bus_clock_output_en(bco), .core_idle(idle));
    rclp_core_model u_core (.aclk(aclk), .go(go), .hold(4'h9), .stop_exec(stop_exec),
        .bus_busy(bus_busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic do_reset(input logic e, input logic [1:0] v);
        @(posedge aclk);
        {en_n, bw, ck, cs, dps} <= {e, v, v, v, v[0]};
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_straps;
        logic [2:0] sel [4] = '{3'h0, 3'h6, 3'h4, 3'h7};
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b0, i[1:0]);
            chk(boot_cfg, i);
            chk(clk_cfg, i);
            chk(cs_sel, sel[i]);
            chk(jtag, i[0]);
            axi_rd(12'h008);
            chk(d, {24'h0, 1'b1, i[0], i[1:0], i[1:0], i[1:0]});
        end
        bw <= 2'h1;
        cs <= 2'h0;
        repeat (4) @(posedge aclk);
        chk({boot_cfg, cs_sel}, {2'h3, 3'h7});
        do_reset(1'b1, 2'h1);
        chk({boot_cfg, clk_cfg, cs_sel}, {2'h0, 2'h3, 3'h0});
    endtask
    task automatic t_regs;
        axi_rd(12'h004);
        chk(d, 32'h0000_00FF);
        axi_rd(12'h010);
        chk(r, 2'h2);
        axi_wr(12'h010, 32'h0000_0003);
        chk(r, 2'h2);
        axi_wr(12'h000, 32'h0000_0004);
        @(posedge aclk);
        chk({bco, mode, idle}, 4'h0);
        axi_wr(12'h000, 32'h0000_0000);
        @(posedge aclk);
        chk(bco, 1);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (15) @(posedge aclk);
        chk(idle, 0);
    endtask
    // enter mode m, then wake by interrupt, break pin or debug request bit
    task automatic t_lp(input logic [1:0] m, input int src);
        int n;
        axi_wr(12'h004, 32'h0000_005A);
        axi_wr(12'h000, {30'h0, m});
        @(posedge aclk);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        chk(pen, 8'h5A);
        n = 0;
        while (!idle && n < 60) begin @(posedge aclk); n++; end
        chk(n > 7 && n < 60, 1);
        @(posedge aclk);
        chk(mode, m);
        chk({core_en, mem_en, sys_en, bco}, {2'h0, m != 2'h3, m != 2'h3});
        chk(pen, m == 2'h3 ? 8'h00 : 8'h5A);
        if (src == 0) irq <= 1'b1;
        if (src == 1) brk_n <= 1'b0;
        if (src == 2) axi_wr(12'h000, {28'h0, 2'h2, m});
        n = 0;
        while (idle && n < 20) begin @(posedge aclk); n++; end
        chk(n < 20, 1);
        @(posedge aclk);
        {irq, brk_n} <= 2'h1;
        chk({mode, core_en, pen}, {2'h0, 1'b1, 8'h5A});
        axi_wr(12'h000, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_straps();
        t_regs();
        t_lp(2'h1, 0);
        t_lp(2'h2, 2);
        t_lp(2'h3, 1);
        test_done();
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        test_done();
    end
endmodule // rclp_ctrl_tb
`default_nettype wire
